/* src/page_relocation_params.svh */
// Constants for the page relocation and write protection unit
`ifndef PAGE_RELOCATION_PARAMS_SVH
`define PAGE_RELOCATION_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PRP_PROG_ADDR_W   15
`define PRP_PHYS_ADDR_W   18
`define PRP_ENTRY_W       12
`define PRP_WORD_W        24
`define PRP_PAGE_W        7
`define PRP_QTR_W         2
`define PRP_GROUP_W       3
`define PRP_INDEX_W       7
`define PRP_WORD_IDX_W    6
`define PRP_PIF_WORDS     64

// ----------------------------------------------------------------
// Field positions of one index entry
// ----------------------------------------------------------------
`define PRP_EXCL_BIT      11
`define PRP_QCNT_MSB      10
`define PRP_QCNT_LSB      9
`define PRP_PAGE_MSB      8
`define PRP_PAGE_LSB      2
`define PRP_START_MSB     1
`define PRP_START_LSB     0

// ----------------------------------------------------------------
// Program and physical address positions
// ----------------------------------------------------------------
`define PRP_ENTRY_SEL_MSB 14
`define PRP_ENTRY_SEL_LSB 11
`define PRP_HALF_BIT      11
`define PRP_QTR_MSB       10
`define PRP_QTR_LSB       9
`define PRP_OFFS_MSB      8
`define PRP_BUS_SEL_BIT   17

// ----------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------
`define PRP_ENTRY_RST     12'h000
`define PRP_WORD_RST      24'h000000
`define PRP_GROUP_RST     3'h0
`define PRP_PHYS_RST      18'h00000
`define PRP_PAGE_ZERO_IDX 7'h00
`define PRP_QTR_ZERO      2'h0
`define PRP_PAGE_ZERO     7'h00

`endif

/* src/page_relocation_pkg.sv */
// Types for the page relocation and write protection unit
`include "page_relocation_params.svh"

package page_relocation_pkg;

  // ----------------------------------------------------------------
  // One page index entry
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    write_exclusion;
    logic [`PRP_QTR_W-1:0]   quarter_count;
    logic [`PRP_PAGE_W-1:0]  physical_page_number;
    logic [`PRP_QTR_W-1:0]   start_quarter;
  } page_entry_type;

  // ----------------------------------------------------------------
  // Relocation state for operand references
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_INSTR_STATE = 1'b0,
    ST_OPER_STATE  = 1'b1
  } relocate_state_type;

endpackage : page_relocation_pkg

/* src/xlate_if.sv */
// Carrier between index lookup and quarter translation
`timescale 1ns/1ps
`include "page_relocation_params.svh"

interface xlate_if;
  import page_relocation_pkg::*;

  page_entry_type                entry;
  logic [`PRP_PROG_ADDR_W-1:0]   prog_addr;
  logic                          page_zero;
  logic                          suppress_len;
  logic [`PRP_PHYS_ADDR_W-1:0]   phys_addr;
  logic                          read_only;
  logic                          unaddressable;
  logic                          len_violation;

  modport lookup (
    output entry, prog_addr, page_zero, suppress_len,
    input  phys_addr, read_only, unaddressable, len_violation
  );

  modport translator (
    input  entry, prog_addr, page_zero, suppress_len,
    output phys_addr, read_only, unaddressable, len_violation
  );
endinterface : xlate_if

/* src/quarter_translate.sv */
// Quarter adder, address assembly and entry checks
`timescale 1ns/1ps
`include "page_relocation_params.svh"

module quarter_translate
  import page_relocation_pkg::*;
(
  // Lookup side
  xlate_if.translator x
);

  logic [`PRP_PAGE_W-1:0] eff_page;
  logic [`PRP_QTR_W-1:0]  eff_start;
  logic [`PRP_QTR_W-1:0]  rel_qtr;
  logic [`PRP_QTR_W-1:0]  phys_qtr;
  logic                   others_zero;

  // ----------------------------------------------------------------
  // Page zero forcing
  // ----------------------------------------------------------------
  assign eff_page  = x.page_zero ? `PRP_PAGE_ZERO : x.entry.physical_page_number;
  assign eff_start = x.page_zero ? `PRP_QTR_ZERO : x.entry.start_quarter;

  // ----------------------------------------------------------------
  // Quarter adder, carry dropped
  // ----------------------------------------------------------------
  assign rel_qtr  = x.prog_addr[`PRP_QTR_MSB:`PRP_QTR_LSB];
  assign phys_qtr = `PRP_QTR_W'(rel_qtr + eff_start);

  // ----------------------------------------------------------------
  // Physical address
  // ----------------------------------------------------------------
  assign x.phys_addr = {eff_page, phys_qtr, x.prog_addr[`PRP_OFFS_MSB:0]};

  // ----------------------------------------------------------------
  // Entry checks
  // ----------------------------------------------------------------
  assign others_zero = (x.entry.quarter_count == `PRP_QTR_ZERO) &&
                       (x.entry.physical_page_number == `PRP_PAGE_ZERO) &&
                       (x.entry.start_quarter == `PRP_QTR_ZERO);
  assign x.unaddressable = x.entry.write_exclusion && others_zero;
  assign x.read_only     = x.entry.write_exclusion && !others_zero;
  assign x.len_violation = !x.suppress_len &&
                           (x.entry.quarter_count != `PRP_QTR_ZERO) &&
                           (rel_qtr >= x.entry.quarter_count);

endmodule : quarter_translate

/* src/page_relocation_protection.sv */
// Page relocation and write protection unit
//
// Function
// - Entry holds exclusion, quarter count, page, start
// - Exclusion clear permits reads and writes
// - Exclusion set, fields nonzero: read only, trap writes
// - Exclusion set, fields zero: unaddressable, trap
// - Seven-bit page picks one of 128 pages
// - Physical bit 17 selects left or right bus
// - Quarter count limits referenced quarters from start
// - Start quarter picks first physical quarter
// - Add start quarter to address bits 9-10
// - Relative quarter at or above a nonzero count traps
// - No length trap in monitor state or I/O
// - Physical address: page, quarter sum, low nine bits
// - Index location zero forces page and start zero
// - Group picks area, upper bits pick entry
// - Address bit 11 picks half of word
// - Group from select registers, zero in monitor state except operand refs in operand state, accumulator for I/O
`timescale 1ns/1ps
`include "page_relocation_params.svh"

module page_relocation_protection
  import page_relocation_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Reference request
  input  wire logic                        i_ref_valid,
  input  wire logic [`PRP_PROG_ADDR_W-1:0] i_prog_addr,
  input  wire logic                        i_ref_write,
  input  wire logic                        i_ref_instr,
  input  wire logic                        i_io_operand,
  input  wire logic [`PRP_GROUP_W-1:0]     i_acc_group,
  // Operating state
  input  wire logic                        i_monitor_state,
  input  wire logic                        i_enter_monitor,
  input  wire logic                        i_relocate_operand,
  input  wire logic                        i_relocate_instr,
  input  wire logic                        i_grp_load_instr,
  input  wire logic                        i_grp_load_oper,
  input  wire logic [`PRP_GROUP_W-1:0]     i_grp_data,
  // Index file access
  input  wire logic                        i_pif_wr_en,
  input  wire logic [`PRP_INDEX_W-1:0]     i_pif_addr,
  input  wire logic [`PRP_ENTRY_W-1:0]     i_pif_wr_data,
  // Storage side
  output logic                             o_ref_done,
  output logic [`PRP_PHYS_ADDR_W-1:0]      o_phys_addr,
  output logic                             o_left_bus,
  output logic                             o_right_bus,
  output logic                             o_store_read,
  output logic                             o_store_write,
  // Processor side
  output logic                             o_illegal_write_irq,
  output logic [`PRP_ENTRY_W-1:0]          o_pif_rd_data,
  output logic [`PRP_GROUP_W-1:0]          o_instruction_group_select,
  output logic [`PRP_GROUP_W-1:0]          o_operand_group_select,
  output logic                             o_operand_state
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`PRP_WORD_W-1:0]       pif_ff      [`PRP_PIF_WORDS];
  logic [`PRP_WORD_W-1:0]       nxt_pif     [`PRP_PIF_WORDS];
  logic [`PRP_GROUP_W-1:0]      isr_ff;
  logic [`PRP_GROUP_W-1:0]      nxt_isr;
  logic [`PRP_GROUP_W-1:0]      osr_ff;
  logic [`PRP_GROUP_W-1:0]      nxt_osr;
  relocate_state_type           rstate_ff;
  relocate_state_type           nxt_rstate;
  logic [`PRP_GROUP_W-1:0]      ref_group;
  logic [`PRP_INDEX_W-1:0]      ref_index;
  logic [`PRP_WORD_W-1:0]       ref_word;
  page_entry_type               ref_entry;
  logic [`PRP_WORD_W-1:0]       host_word;
  logic                         illegal;
  logic                         blocked;
  logic                         done_ff;
  logic                         nxt_done;
  logic [`PRP_PHYS_ADDR_W-1:0]  phys_ff;
  logic [`PRP_PHYS_ADDR_W-1:0]  nxt_phys;
  logic                         left_ff;
  logic                         nxt_left;
  logic                         right_ff;
  logic                         nxt_right;
  logic                         sread_ff;
  logic                         nxt_sread;
  logic                         swrite_ff;
  logic                         nxt_swrite;
  logic                         irq_ff;
  logic                         nxt_irq;
  logic [`PRP_ENTRY_W-1:0]      rd_ff;
  logic [`PRP_ENTRY_W-1:0]      nxt_rd;

  xlate_if x ();

  // ----------------------------------------------------------------
  // Group select registers and relocation state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_isr    = i_grp_load_instr ? i_grp_data : isr_ff;
    nxt_osr    = i_grp_load_oper ? i_grp_data : osr_ff;
    nxt_rstate = rstate_ff;
    case (rstate_ff)
      ST_INSTR_STATE: begin
        if (i_relocate_operand && !i_enter_monitor && !i_relocate_instr) begin
          nxt_rstate = ST_OPER_STATE;
        end
      end
      ST_OPER_STATE: begin
        if (i_enter_monitor || i_relocate_instr) begin
          nxt_rstate = ST_INSTR_STATE;
        end
      end
      default: begin
        nxt_rstate = ST_INSTR_STATE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      isr_ff    <= `PRP_GROUP_RST;
      osr_ff    <= `PRP_GROUP_RST;
      rstate_ff <= ST_INSTR_STATE;
    end else begin
      isr_ff    <= nxt_isr;
      osr_ff    <= nxt_osr;
      rstate_ff <= nxt_rstate;
    end
  end

  // ----------------------------------------------------------------
  // Address group source
  // ----------------------------------------------------------------
  always_comb begin
    if (!i_ref_instr && i_io_operand) begin
      ref_group = i_acc_group;
    end else if (!i_ref_instr && rstate_ff == ST_OPER_STATE) begin
      ref_group = osr_ff;
    end else if (i_monitor_state) begin
      ref_group = `PRP_GROUP_RST;
    end else begin
      ref_group = isr_ff;
    end
  end

  // ----------------------------------------------------------------
  // Index file lookup
  // ----------------------------------------------------------------
  assign ref_index = {ref_group,
                      i_prog_addr[`PRP_ENTRY_SEL_MSB:`PRP_ENTRY_SEL_LSB]};
  assign ref_word  = pif_ff[ref_index[`PRP_INDEX_W-1:1]];
  assign ref_entry = i_prog_addr[`PRP_HALF_BIT] ? ref_word[`PRP_WORD_W-1:`PRP_ENTRY_W]
                                                : ref_word[`PRP_ENTRY_W-1:0];

  assign x.entry        = ref_entry;
  assign x.prog_addr    = i_prog_addr;
  assign x.page_zero    = (ref_index == `PRP_PAGE_ZERO_IDX);
  assign x.suppress_len = i_monitor_state || i_io_operand;

  quarter_translate u_qtr (
    .x (x.translator)
  );

  // ----------------------------------------------------------------
  // Index file storage
  // ----------------------------------------------------------------
  assign host_word = pif_ff[i_pif_addr[`PRP_INDEX_W-1:1]];

  always_comb begin
    for (int w = 0; w < `PRP_PIF_WORDS; w++) begin
      nxt_pif[w] = pif_ff[w];
    end
    if (i_pif_wr_en) begin
      if (i_pif_addr[0]) begin
        nxt_pif[i_pif_addr[`PRP_INDEX_W-1:1]] = {i_pif_wr_data, host_word[`PRP_ENTRY_W-1:0]};
      end else begin
        nxt_pif[i_pif_addr[`PRP_INDEX_W-1:1]] =
          {host_word[`PRP_WORD_W-1:`PRP_ENTRY_W], i_pif_wr_data};
      end
    end
    nxt_rd = i_pif_addr[0] ? host_word[`PRP_WORD_W-1:`PRP_ENTRY_W]
                           : host_word[`PRP_ENTRY_W-1:0];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int w = 0; w < `PRP_PIF_WORDS; w++) begin
        pif_ff[w] <= `PRP_WORD_RST;
      end
      rd_ff <= `PRP_ENTRY_RST;
    end else begin
      for (int w = 0; w < `PRP_PIF_WORDS; w++) begin
        pif_ff[w] <= nxt_pif[w];
      end
      rd_ff <= nxt_rd;
    end
  end

  // ----------------------------------------------------------------
  // Protection and storage answer
  // ----------------------------------------------------------------
  assign illegal = x.unaddressable || x.len_violation ||
                   (x.read_only && i_ref_write);
  assign blocked = x.unaddressable || x.len_violation;

  always_comb begin
    nxt_done   = i_ref_valid;
    nxt_phys   = i_ref_valid ? x.phys_addr : phys_ff;
    nxt_left   = i_ref_valid && x.phys_addr[`PRP_BUS_SEL_BIT];
    nxt_right  = i_ref_valid && !x.phys_addr[`PRP_BUS_SEL_BIT];
    nxt_sread  = i_ref_valid && !i_ref_write && !blocked;
    nxt_swrite = i_ref_valid && i_ref_write && !illegal;
    nxt_irq    = i_ref_valid && illegal;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_ff   <= 1'b0;
      phys_ff   <= `PRP_PHYS_RST;
      left_ff   <= 1'b0;
      right_ff  <= 1'b0;
      sread_ff  <= 1'b0;
      swrite_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      done_ff   <= nxt_done;
      phys_ff   <= nxt_phys;
      left_ff   <= nxt_left;
      right_ff  <= nxt_right;
      sread_ff  <= nxt_sread;
      swrite_ff <= nxt_swrite;
      irq_ff    <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_ref_done                 = done_ff;
  assign o_phys_addr                = phys_ff;
  assign o_left_bus                 = left_ff;
  assign o_right_bus                = right_ff;
  assign o_store_read               = sread_ff;
  assign o_store_write              = swrite_ff;
  assign o_illegal_write_irq        = irq_ff;
  assign o_pif_rd_data              = rd_ff;
  assign o_instruction_group_select = isr_ff;
  assign o_operand_group_select     = osr_ff;
  assign o_operand_state            = (rstate_ff == ST_OPER_STATE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_trap_answer;
    ##1 o_illegal_write_irq && !o_store_write;
  endsequence

  sequence s_clean_answer;
    ##1 !o_illegal_write_irq;
  endsequence

  a_free_page_rw: assert property (
    i_ref_valid && !ref_entry.write_exclusion && !x.len_violation
      |=> o_store_write == $past(i_ref_write) && o_store_read == !$past(i_ref_write)
          && !o_illegal_write_irq)
    else $error("free page reference not passed to storage");

  a_read_only_trap: assert property (
    i_ref_valid && x.read_only && i_ref_write |-> s_trap_answer)
    else $error("write to read only page not trapped");

  a_unaddr_trap: assert property (
    i_ref_valid && x.unaddressable |-> s_trap_answer ##0 !o_store_read)
    else $error("unaddressable page not trapped");

  a_bus_select: assert property (
    o_ref_done |-> o_left_bus == o_phys_addr[17] && o_right_bus == !o_phys_addr[17])
    else $error("storage bus select wrong");

  a_low_bits_pass: assert property (
    i_ref_valid |=> o_phys_addr[8:0] == $past(i_prog_addr[8:0]) && o_ref_done)
    else $error("low address bits altered");

  a_quarter_sum: assert property (
    i_ref_valid && !x.page_zero
      |=> o_phys_addr[10:9] == 2'($past(i_prog_addr[10:9]) + $past(ref_entry.start_quarter))
          && o_phys_addr[17:11] == $past(ref_entry.physical_page_number))
    else $error("quarter sum or page number wrong");

  a_page_zero_map: assert property (
    i_ref_valid && x.page_zero
      |=> o_phys_addr[17:11] == 7'h00 && o_phys_addr[10:9] == $past(i_prog_addr[10:9]))
    else $error("index location zero not forced to page zero");

  a_len_suppress: assert property (
    i_ref_valid && (i_monitor_state || i_io_operand) && !ref_entry.write_exclusion
      |-> s_clean_answer)
    else $error("length trap raised in monitor state or I/O");

  a_length_trap: assert property (
    i_ref_valid && !i_monitor_state && !i_io_operand && ref_entry.quarter_count != 2'h0
      && i_prog_addr[10:9] >= ref_entry.quarter_count |-> s_trap_answer)
    else $error("quarter length violation not trapped");

  a_irq_needs_ref: assert property (
    o_illegal_write_irq |-> $past(i_ref_valid) && o_ref_done)
    else $error("interrupt without a reference");

endmodule : page_relocation_protection

/* tb/core_store_model.sv */
// Core storage model that watches the two storage buses
`timescale 1ns/1ps
`include "page_relocation_params.svh"

module core_store_model (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Storage buses
  input  wire logic                        i_ref_done,
  input  wire logic [`PRP_PHYS_ADDR_W-1:0] i_phys_addr,
  input  wire logic                        i_left_bus,
  input  wire logic                        i_right_bus,
  input  wire logic                        i_store_write,
  // Observations
  output logic [7:0]                       o_write_count,
  output logic                             o_bus_err
);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_write_count <= 8'h00;
      o_bus_err     <= 1'b0;
    end else begin
      // Count committed writes only
      if (i_store_write) o_write_count <= o_write_count + 8'h01;
      if (i_store_write && !i_ref_done) o_bus_err <= 1'b1;
      // One bus per reference, chosen by the top address bit
      if (i_ref_done && (i_left_bus === i_right_bus)) o_bus_err <= 1'b1;
      if (i_left_bus !== (i_ref_done && i_phys_addr[17])) o_bus_err <= 1'b1;
    end
  end
endmodule : core_store_model

/* tb/test_page_relocation_protection.sv */
// Self-checking bench for the page relocation unit
`timescale 1ns/1ps
`include "page_relocation_params.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module test_page_relocation_protection;
  import page_relocation_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mon; logic io; logic instr; logic wr; logic [14:0] addr;
    logic [17:0] phys; logic rd_ok; logic wr_ok; logic irq;
  } row_type;
  localparam row_type ROWS [11] = '{
    '{1'b0, 1'b0, 1'b1, 1'b0, 15'h0400, 18'h22E00, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b1, 15'h0400, 18'h22E00, 1'b0, 1'b1, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b0, 15'h07FF, 18'h229FF, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b0, 15'h0A05, 18'h09205, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b1, 15'h0A05, 18'h00000, 1'b0, 1'b0, 1'b1},
    '{1'b0, 1'b0, 1'b1, 1'b0, 15'h0C00, 18'h00000, 1'b0, 1'b0, 1'b1},
    '{1'b0, 1'b1, 1'b0, 1'b0, 15'h0C00, 18'h09C00, 1'b1, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b1, 15'h1000, 18'h00000, 1'b0, 1'b0, 1'b1},
    '{1'b0, 1'b0, 1'b1, 1'b0, 15'h1000, 18'h00000, 1'b0, 1'b0, 1'b1},
    '{1'b1, 1'b0, 1'b1, 1'b0, 15'h0A00, 18'h01E00, 1'b1, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b1, 1'b1, 15'h0345, 18'h00345, 1'b0, 1'b1, 1'b0}};
  logic        i_clk = 1'b0, i_rst = 1'b1, i_ref_valid = 1'b0, i_ref_write = 1'b0;
  logic        i_ref_instr = 1'b1, i_io_operand = 1'b0, i_monitor_state = 1'b0;
  logic        i_enter_monitor = 1'b0, i_relocate_operand = 1'b0, i_relocate_instr = 1'b0;
  logic        i_grp_load_instr = 1'b0, i_grp_load_oper = 1'b0, i_pif_wr_en = 1'b0;
  logic [14:0] i_prog_addr = 15'h0000;
  logic [2:0]  i_acc_group = 3'h2, i_grp_data = 3'h0;
  logic [6:0]  i_pif_addr = 7'h00;
  logic [11:0] i_pif_wr_data = 12'h000, o_pif_rd_data;
  logic [17:0] o_phys_addr;
  logic [2:0]  o_instruction_group_select, o_operand_group_select;
  logic        o_ref_done, o_left_bus, o_right_bus, o_store_read, o_store_write;
  logic        o_illegal_write_irq, o_operand_state, bus_err;
  logic [7:0]  write_count, exp_writes = 8'h00;
  int          mismatches = 0, cmp_count = 0;

  always #50 i_clk = ~i_clk;

  page_relocation_protection u_dut (.*);
  core_store_model u_store (.i_clk(i_clk), .i_rst(i_rst), .i_ref_done(o_ref_done),
    .i_phys_addr(o_phys_addr), .i_left_bus(o_left_bus), .i_right_bus(o_right_bus),
    .i_store_write(o_store_write), .o_write_count(write_count), .o_bus_err(bus_err));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic pif_write(input logic [6:0] idx, input logic [11:0] data);
    i_pif_wr_en   = 1'b1;
    i_pif_addr    = idx;
    i_pif_wr_data = data;
    @(negedge i_clk);
    i_pif_wr_en = 1'b0;
    @(negedge i_clk);
  endtask : pif_write

  task automatic do_ref(input row_type r);
    i_monitor_state = r.mon;
    i_io_operand    = r.io;
    i_ref_instr     = r.instr;
    i_ref_write     = r.wr;
    i_prog_addr     = r.addr;
    i_ref_valid     = 1'b1;
    @(negedge i_clk);
    i_ref_valid = 1'b0;
    `CHK("done", 1'b1, o_ref_done)
    `CHK("irq", r.irq, o_illegal_write_irq)
    `CHK("store_write", r.wr_ok, o_store_write)
    `CHK("store_read", r.rd_ok, o_store_read)
    if (!r.irq) begin
      `CHK("phys", r.phys, o_phys_addr)
      `CHK("left", r.phys[17], o_left_bus)
      `CHK("right", !r.phys[17], o_right_bus)
    end
    if (r.wr_ok) exp_writes++;
    @(negedge i_clk);
    `CHK("done drop", 1'b0, o_ref_done)
    `CHK("irq drop", 1'b0, o_illegal_write_irq)
  endtask : do_ref

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #(2000 * 100);
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    `CHK("rst rd_data", 12'h000, o_pif_rd_data)
    `CHK("rst isr", 3'h0, o_instruction_group_select)
    `CHK("rst state", 1'b0, o_operand_state)
    `CHK("rst done", 1'b0, o_ref_done)
    i_grp_data       = 3'h1;
    i_grp_load_instr = 1'b1;
    @(negedge i_clk);
    i_grp_load_instr = 1'b0;
    `CHK("isr", 3'h1, o_instruction_group_select)
    $display("Test reset and group load done");
    pif_write(7'h10, 12'h115);
    pif_write(7'h11, 12'hC48);
    pif_write(7'h12, 12'h800);
    pif_write(7'h21, 12'hC4C);
    pif_write(7'h01, 12'h20E);
    pif_write(7'h00, 12'h1FF);
    i_pif_addr = 7'h11;
    @(negedge i_clk);
    `CHK("entry", 12'hC48, o_pif_rd_data)
    foreach (ROWS[k]) do_ref(ROWS[k]);
    `CHK("writes", exp_writes, write_count)
    `CHK("bus", 1'b0, bus_err)
    $display("Test reference rows done");
    // Written entry reads old, then new
    i_pif_wr_en   = 1'b1;
    i_pif_addr    = 7'h28;
    i_pif_wr_data = 12'hABC;
    @(negedge i_clk);
    i_pif_wr_en = 1'b0;
    `CHK("rd old", 12'h000, o_pif_rd_data)
    @(negedge i_clk);
    `CHK("rd new", 12'hABC, o_pif_rd_data)
    $display("Test index file port done");
    // Operand group select and state transitions
    i_grp_data         = 3'h2;
    i_grp_load_oper    = 1'b1;
    i_relocate_operand = 1'b1;
    @(negedge i_clk);
    i_grp_load_oper    = 1'b0;
    i_relocate_operand = 1'b0;
    `CHK("osr", 3'h2, o_operand_group_select)
    `CHK("oper state", 1'b1, o_operand_state)
    pif_write(7'h20, 12'h004);
    do_ref('{1'b0, 1'b0, 1'b0, 1'b0, 15'h0010, 18'h00810, 1'b1, 1'b0, 1'b0});
    i_relocate_instr   = 1'b1;
    i_relocate_operand = 1'b1;
    @(negedge i_clk);
    i_relocate_instr   = 1'b0;
    i_relocate_operand = 1'b0;
    `CHK("relocate instr", 1'b0, o_operand_state)
    i_relocate_operand = 1'b1;
    @(negedge i_clk);
    i_relocate_operand = 1'b0;
    `CHK("relocate oper", 1'b1, o_operand_state)
    i_enter_monitor    = 1'b1;
    @(negedge i_clk);
    i_enter_monitor = 1'b0;
    `CHK("monitor clears", 1'b0, o_operand_state)
    $display("Test operand state done");
    // Reset in mid-run clears groups and index file
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    `CHK("mid rst osr", 3'h0, o_operand_group_select)
    `CHK("mid rst done", 1'b0, o_ref_done)
    @(negedge i_clk);
    `CHK("mid rst entry", 12'h000, o_pif_rd_data)
    $display("Test mid-run reset done");
    end_sim();
  end
endmodule : test_page_relocation_protection
